// ### hdl/clk_trim_pkg.sv
package clk_trim_pkg;
  // ---------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------
  localparam logic [7:0] ADDR_STATUS_CTRL = 8'h08;
  localparam logic [7:0] ADDR_CTRL_ONE = 8'h00;
  localparam logic [7:0] ADDR_CTRL_THREE = 8'h04;
  localparam logic [7:0] ADDR_CTRL_FOUR = 8'h0C;
  localparam logic [7:0] ADDR_IRQ_STATUS = 8'h10;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h14;
  localparam logic [7:0] ADDR_PLANT = 8'h18;
  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int BIT_TRIM_EN = 7;
  localparam int BIT_TRIM_SEL = 6;
  localparam int BIT_TRIM_FAIL = 5;
  localparam int BIT_PRESERVE = 4;
  localparam int BIT_DIV_HI = 3;
  localparam int BIT_DIV_LO = 1;
  localparam int BIT_LOSS = 0;
  localparam int BIT_MON_EN = 0;
  localparam logic [7:0] SC_RESET = 8'h00;
  localparam logic [7:0] REG_ZERO = 8'h00;
  // Interrupt status bits
  localparam int IRQ_DONE = 0;
  localparam int IRQ_FAIL = 1;
  localparam int IRQ_LOSS = 2;
  localparam int IRQ_W = 3;
  localparam int TRIM_BITS = 8;

  typedef struct packed {
    logic trim_enable;
    logic trim_select;
    logic trim_fail_flag;
    logic loop_filter_preserve;
    logic [2:0] fast_ref_divider;
    logic osc_loss_status;
  } sc_reg_s;

  typedef enum logic [1:0] {
    TRIM_IDLE = 2'b00,
    TRIM_RUN = 2'b01
  } trim_state_e;
endpackage : clk_trim_pkg

// ### hdl/clock_trim_status_control.sv
// Our own choice: the APB register port.
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// [RULE_01] Setting trim_enable starts auto trim on the selected clock.
// [RULE_02] trim_enable clears itself when all trim bits are adjusted.
// [RULE_03] Writes to control regs one/three/four/this, or stop, abort trim.
// [RULE_04] trim_select: 0 picks 32 kHz clock, 1 picks 4 MHz clock.
// [RULE_05] While trimming, such writes or stop entry set trim_fail_flag.
// [RULE_06] A software write to trim_fail_flag clears it.
// [RULE_07] trim_fail_flag 0 means completed normally, 1 means aborted.
// [RULE_08] Preserve bit 1 keeps loop filter over mode changes.
// [RULE_09] Preserve bit 0 resets loop filter on each mode change.
// [RULE_10] Software keeps loop reference frequency for preservation to hold.
// [RULE_11] Divider field divides fast clock by two to the field value.
// [RULE_12] Software must not change divider while fast clock enabled.
// [RULE_13] osc_loss_status becomes 1 on external oscillator loss.
// [RULE_14] Loss status only takes effect while monitor enable is set.
// [RULE_15] Writing 1 clears loss status; writing 0 leaves it.
// [RULE_16] All fields reset to zero.
module clock_trim_status_control
  import clk_trim_pkg::*;
#(
  parameter int TRIM_STEP_CYCLES = 4
)(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic stop_entry,
  input wire logic osc_loss_event,
  input wire logic mode_change,
  input wire logic trim_bit_done,
  output logic trim_active,
  output logic trim_target_fast,
  output logic [7:0] fast_div_ratio,
  output logic [2:0] fast_ref_divider,
  output logic loop_filter_reset,
  output logic irq
);
  // ---------------------------------------------------------------
  // Input synchronisers
  // ---------------------------------------------------------------
  logic stop_s1_r, stop_s2_r, loss_s1_r, loss_s2_r;
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      stop_s1_r <= 1'b0;
      stop_s2_r <= 1'b0;
      loss_s1_r <= 1'b0;
      loss_s2_r <= 1'b0;
    end
    else
    begin
      stop_s1_r <= stop_entry;
      stop_s2_r <= stop_s1_r;
      loss_s1_r <= osc_loss_event;
      loss_s2_r <= loss_s1_r;
    end
  end

  // ---------------------------------------------------------------
  // Bus decode
  // ---------------------------------------------------------------
  wire acc = psel && penable;
  wire wr = acc && pwrite;
  wire rd = acc && !pwrite;
  wire hit_sc = paddr == ADDR_STATUS_CTRL;
  wire hit_c1 = paddr == ADDR_CTRL_ONE;
  wire hit_c3 = paddr == ADDR_CTRL_THREE;
  wire hit_c4 = paddr == ADDR_CTRL_FOUR;
  wire hit_is = paddr == ADDR_IRQ_STATUS;
  wire hit_im = paddr == ADDR_IRQ_MASK;
  wire hit_pl = paddr == ADDR_PLANT;
  wire mapped = hit_sc | hit_c1 | hit_c3 | hit_c4 | hit_is | hit_im
                | hit_pl;
  wire wr_sc = wr && hit_sc;
  wire abort_wr = wr && (hit_sc | hit_c1 | hit_c3 | hit_c4);
  assign pready = 1'b1;
  assign pslverr = acc && !mapped;

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  sc_reg_s sc_r, sc_nxt;
  logic [7:0] c1_r, c3_r, c4_r, plant_r;
  logic [IRQ_W-1:0] ist_r, ist_nxt, imask_r;
  trim_state_e st_r, st_nxt;
  logic [3:0] bit_cnt_r, bit_cnt_nxt;
  logic [31:0] prdata_nxt;

  wire mon_en = plant_r[BIT_MON_EN];
  wire abort = (abort_wr || stop_s2_r) && st_r == TRIM_RUN;
  wire start = wr_sc && pwdata[BIT_TRIM_EN] && st_r == TRIM_IDLE;
  wire finish = st_r == TRIM_RUN && !abort && trim_bit_done
                && bit_cnt_r == 4'(TRIM_BITS - 1);
  wire loss_set = loss_s2_r && mon_en;

  always_comb
  begin
    sc_nxt = sc_r;
    st_nxt = st_r;
    bit_cnt_nxt = bit_cnt_r;
    if (wr_sc)
    begin
      sc_nxt.trim_select = pwdata[BIT_TRIM_SEL]; // see [RULE_04]
      sc_nxt.loop_filter_preserve = pwdata[BIT_PRESERVE]; // see [RULE_08]
      sc_nxt.fast_ref_divider = pwdata[BIT_DIV_HI:BIT_DIV_LO]; // see [RULE_11]
      sc_nxt.trim_fail_flag = 1'b0; // see [RULE_06]
      if (pwdata[BIT_LOSS])
        sc_nxt.osc_loss_status = 1'b0; // see [RULE_15]
    end
    if (start)
    begin
      st_nxt = TRIM_RUN; // see [RULE_01]
      bit_cnt_nxt = 4'h0;
      sc_nxt.trim_enable = 1'b1;
    end
    else if (abort)
    begin
      st_nxt = TRIM_IDLE; // see [RULE_03]
      sc_nxt.trim_enable = 1'b0;
      sc_nxt.trim_fail_flag = 1'b1; // see [RULE_05] [RULE_07]
    end
    else if (finish)
    begin
      st_nxt = TRIM_IDLE; // see [RULE_02]
      sc_nxt.trim_enable = 1'b0;
    end
    else if (st_r == TRIM_RUN && trim_bit_done)
      bit_cnt_nxt = bit_cnt_r + 4'h1;
    if (loss_set)
      sc_nxt.osc_loss_status = 1'b1; // see [RULE_13] [RULE_14]
  end

  always_comb
  begin
    ist_nxt = ist_r;
    if (rd && hit_is)
      ist_nxt = '0;
    if (finish)
      ist_nxt[IRQ_DONE] = 1'b1;
    if (abort)
      ist_nxt[IRQ_FAIL] = 1'b1;
    if (loss_set)
      ist_nxt[IRQ_LOSS] = 1'b1;
  end

  always_comb
  begin
    prdata_nxt = 32'h0000_0000;
    if (hit_sc)
      prdata_nxt[7:0] = sc_r;
    else if (hit_c1)
      prdata_nxt[7:0] = c1_r;
    else if (hit_c3)
      prdata_nxt[7:0] = c3_r;
    else if (hit_c4)
      prdata_nxt[7:0] = c4_r;
    else if (hit_is)
      prdata_nxt[IRQ_W-1:0] = ist_r;
    else if (hit_im)
      prdata_nxt[IRQ_W-1:0] = imask_r;
    else if (hit_pl)
      prdata_nxt[7:0] = plant_r;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sc_r <= SC_RESET; // see [RULE_16]
      st_r <= TRIM_IDLE;
      bit_cnt_r <= 4'h0;
      ist_r <= '0;
      prdata <= 32'h0000_0000;
    end
    else
    begin
      sc_r <= sc_nxt;
      st_r <= st_nxt;
      bit_cnt_r <= bit_cnt_nxt;
      ist_r <= ist_nxt;
      prdata <= prdata_nxt;
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      c1_r <= REG_ZERO;
      c3_r <= REG_ZERO;
      c4_r <= REG_ZERO;
      plant_r <= REG_ZERO;
      imask_r <= '0;
    end
    else
    begin
      if (wr && hit_c1)
        c1_r <= pwdata[7:0];
      if (wr && hit_c3)
        c3_r <= pwdata[7:0];
      if (wr && hit_c4)
        c4_r <= pwdata[7:0];
      if (wr && hit_pl)
        plant_r <= pwdata[7:0];
      if (wr && hit_im)
        imask_r <= pwdata[IRQ_W-1:0];
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign trim_active = st_r == TRIM_RUN;
  assign trim_target_fast = sc_r.trim_select; // see [RULE_04]
  assign fast_ref_divider = sc_r.fast_ref_divider;
  assign fast_div_ratio = 8'h01 << sc_r.fast_ref_divider; // see [RULE_11]
  assign loop_filter_reset = mode_change // see [RULE_08] [RULE_09]
    && !sc_r.loop_filter_preserve;
  assign irq = |(ist_r & imask_r);

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  property p_start;
    @(posedge clk) disable iff (!rst_n)
    start |=> sc_r.trim_enable && trim_active;
  endproperty
  a_start: assert property (p_start) // see [RULE_01]
    else $error("trim not started");

  property p_done;
    @(posedge clk) disable iff (!rst_n)
    finish |=> !sc_r.trim_enable && !sc_r.trim_fail_flag;
  endproperty
  a_done: assert property (p_done) // see [RULE_02]
    else $error("trim not finished");

  property p_abort;
    @(posedge clk) disable iff (!rst_n)
    (trim_active && abort_wr) |=> !sc_r.trim_enable && sc_r.trim_fail_flag;
  endproperty
  a_abort: assert property (p_abort) // see [RULE_03]
    else $error("trim not aborted");

  property p_stop;
    @(posedge clk) disable iff (!rst_n)
    (trim_active && stop_s2_r) |=> sc_r.trim_fail_flag && !trim_active;
  endproperty
  a_stop: assert property (p_stop) // see [RULE_05]
    else $error("stop no abort");

  property p_fail_clr;
    @(posedge clk) disable iff (!rst_n)
    (wr_sc && !trim_active) |=> !sc_r.trim_fail_flag;
  endproperty
  a_fail_clr: assert property (p_fail_clr) // see [RULE_06]
    else $error("fail not cleared");

  property p_sel;
    @(posedge clk) disable iff (!rst_n)
    wr_sc |=> trim_target_fast == $past(pwdata[BIT_TRIM_SEL]);
  endproperty
  a_sel: assert property (p_sel) // see [RULE_04]
    else $error("select wrong");

  property p_div;
    @(posedge clk) disable iff (!rst_n)
    wr_sc |=> fast_ref_divider == $past(pwdata[BIT_DIV_HI:BIT_DIV_LO])
      && $onehot(fast_div_ratio) && fast_div_ratio[fast_ref_divider];
  endproperty
  a_div: assert property (p_div) // see [RULE_11]
    else $error("divider wrong");

  property p_loss;
    @(posedge clk) disable iff (!rst_n)
    ($rose(osc_loss_event) && mon_en) ##2 mon_en |=> sc_r.osc_loss_status;
  endproperty
  a_loss: assert property (p_loss) // see [RULE_13]
    else $error("loss not set");

  property p_loss_gate;
    @(posedge clk) disable iff (!rst_n)
    (!loss_set && !sc_r.osc_loss_status) |=> !sc_r.osc_loss_status;
  endproperty
  a_loss_gate: assert property (p_loss_gate) // see [RULE_14]
    else $error("loss spurious");

  property p_loss_clr;
    @(posedge clk) disable iff (!rst_n)
    (wr_sc && pwdata[BIT_LOSS] && !loss_set) |=> !sc_r.osc_loss_status;
  endproperty
  a_loss_clr: assert property (p_loss_clr) // see [RULE_15]
    else $error("loss not cleared");

  property p_filt;
    @(posedge clk) disable iff (!rst_n)
    (mode_change && sc_r.loop_filter_preserve) |-> !loop_filter_reset;
  endproperty
  a_filt: assert property (p_filt) // see [RULE_08]
    else $error("filter reset");

  c_done: cover property (@(posedge clk) disable iff (!rst_n) finish);
  c_abort: cover property (@(posedge clk) disable iff (!rst_n) abort);
  c_loss: cover property (@(posedge clk) disable iff (!rst_n) loss_set);
  c_irq: cover property (@(posedge clk) disable iff (!rst_n) irq);
endmodule : clock_trim_status_control
`default_nettype wire

// ### bench/clock_trim_status_control_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module clock_trim_status_control_tb_top
  import clk_trim_pkg::*;
;
  logic clk, rst_n, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr, fast_div_ratio;
  logic [31:0] pwdata, prdata, rdat;
  logic stop_entry, osc_loss_event, mode_change, trim_bit_done, err;
  logic trim_active, trim_target_fast, loop_filter_reset, irq;
  logic [2:0] fast_ref_divider;
  logic [7:0] abort_addr [4];
  int fail_count, compares, cycles;

  clock_trim_status_control i_clock_trim_status_control (
    .clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .stop_entry(stop_entry),
    .osc_loss_event(osc_loss_event), .mode_change(mode_change),
    .trim_bit_done(trim_bit_done), .trim_active(trim_active),
    .trim_target_fast(trim_target_fast), .fast_div_ratio(fast_div_ratio),
    .fast_ref_divider(fast_ref_divider),
    .loop_filter_reset(loop_filter_reset), .irq(irq));

  // ---------------------------------------------------------------
  // Clock and timeout
  // ---------------------------------------------------------------
  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  always @(posedge clk)
  begin
    cycles++;
    if (cycles > 4000)
    begin
      fail_count++;
      test_done();
    end
  end

  // ---------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------
  task automatic test_done();
    if (fail_count == 0 && compares > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : test_done

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      fail_count++;
      $display("BAD t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do
      @(posedge clk);
    while (pready !== 1'b1);
    rdat = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rdat, exp);
  endtask : rd

  task automatic bits(input int n);
    repeat (n)
    begin
      @(posedge clk) trim_bit_done <= 1'b1;
      @(posedge clk) trim_bit_done <= 1'b0;
    end
    @(negedge clk);
  endtask : bits

  task automatic lvl(input bit stop);
    @(posedge clk);
    if (stop)
      stop_entry <= 1'b1;
    else
      osc_loss_event <= 1'b1;
    repeat (4) @(posedge clk);
    stop_entry <= 1'b0;
    osc_loss_event <= 1'b0;
    repeat (4) @(posedge clk);
  endtask : lvl

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial
  begin
    {rst_n, psel, penable, pwrite, paddr, pwdata} = '0;
    {stop_entry, osc_loss_event, mode_change, trim_bit_done} = '0;
    abort_addr = '{ADDR_CTRL_ONE, ADDR_CTRL_THREE, ADDR_CTRL_FOUR,
                   ADDR_STATUS_CTRL};
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    rd(ADDR_STATUS_CTRL, 32'h00);
    chk({31'h0, err}, 32'h0);
    apb(1'b1, 8'h1C, 32'hFF);
    chk({31'h0, err}, 32'h1);
    rd(8'h1C, 32'h0);
    chk({31'h0, err}, 32'h1);
    // Fast clock stays off while the divider moves
    for (int i = 0; i < 8; i++)
    begin
      wr(ADDR_STATUS_CTRL, 32'(i) << 1);
      @(negedge clk);
      chk({24'h0, fast_div_ratio}, 32'h1 << i);
      chk({29'h0, fast_ref_divider}, 32'(i));
    end
    wr(ADDR_STATUS_CTRL, 32'h10);
    // Loop reference left unchanged across the mode change
    @(posedge clk) mode_change <= 1'b1;
    @(negedge clk) chk({31'h0, loop_filter_reset}, 32'h0);
    @(posedge clk) mode_change <= 1'b0;
    wr(ADDR_STATUS_CTRL, 32'h00);
    @(posedge clk) mode_change <= 1'b1;
    @(negedge clk) chk({31'h0, loop_filter_reset}, 32'h1);
    @(posedge clk) mode_change <= 1'b0;
    wr(ADDR_IRQ_MASK, 32'h7);
    wr(ADDR_STATUS_CTRL, 32'hC0);
    @(negedge clk) chk({31'h0, trim_active}, 32'h1);
    chk({31'h0, trim_target_fast}, 32'h1);
    rd(ADDR_STATUS_CTRL, 32'hC0);
    bits(TRIM_BITS - 1);
    chk({31'h0, trim_active}, 32'h1);
    bits(1);
    chk({31'h0, trim_active}, 32'h0);
    rd(ADDR_STATUS_CTRL, 32'h40);
    chk({31'h0, irq}, 32'h1);
    rd(ADDR_IRQ_STATUS, 32'h1);
    @(negedge clk) chk({31'h0, irq}, 32'h0);
    wr(ADDR_CTRL_ONE, 32'h0);
    rd(ADDR_STATUS_CTRL, 32'h40);
    for (int i = 0; i < 4; i++)
    begin
      wr(ADDR_STATUS_CTRL, 32'h00);
      wr(ADDR_STATUS_CTRL, 32'h80);
      @(negedge clk) chk({31'h0, trim_target_fast}, 32'h0);
      wr(abort_addr[i], 32'h0);
      @(negedge clk) chk({31'h0, trim_active}, 32'h0);
      rd(ADDR_STATUS_CTRL, 32'h20);
      rd(ADDR_IRQ_STATUS, 32'h2);
    end
    wr(ADDR_STATUS_CTRL, 32'h00);
    wr(ADDR_STATUS_CTRL, 32'h80);
    lvl(1'b1);
    chk({31'h0, trim_active}, 32'h0);
    rd(ADDR_STATUS_CTRL, 32'h20);
    wr(ADDR_STATUS_CTRL, 32'h20);
    rd(ADDR_STATUS_CTRL, 32'h00);
    wr(ADDR_IRQ_MASK, 32'h0);
    rd(ADDR_IRQ_STATUS, 32'h2);
    lvl(1'b0);
    rd(ADDR_STATUS_CTRL, 32'h00);
    wr(ADDR_PLANT, 32'h1);
    lvl(1'b0);
    rd(ADDR_STATUS_CTRL, 32'h01);
    chk({31'h0, irq}, 32'h0);
    wr(ADDR_IRQ_MASK, 32'h7);
    @(negedge clk) chk({31'h0, irq}, 32'h1);
    rd(ADDR_IRQ_STATUS, 32'h4);
    wr(ADDR_STATUS_CTRL, 32'h00);
    rd(ADDR_STATUS_CTRL, 32'h01);
    wr(ADDR_STATUS_CTRL, 32'h01);
    rd(ADDR_STATUS_CTRL, 32'h00);
    test_done();
  end
endmodule : clock_trim_status_control_tb_top
`default_nettype wire
